// [pkg/ofs_pkg.sv]
// constants of the digital output function selector
package ofs_pkg;
    localparam int N_OUT = 8;
    localparam int SEL_W = 7;
    localparam int SRC_N = 128;
    localparam int N_ALM = 17;

    // -------------------------------------------------------------------
    // selection codes
    // -------------------------------------------------------------------
    localparam logic [6:0] C_OFF = 7'h00;
    localparam logic [6:0] C_SPD_ZERO = 7'h01;
    localparam logic [6:0] C_SPD_THR = 7'h02;
    localparam logic [6:0] C_SPD_SET = 7'h03;
    localparam logic [6:0] C_CUR_LIM = 7'h04;
    localparam logic [6:0] C_DRV_RDY = 7'h05;
    localparam logic [6:0] C_MOT_OVL_FREE = 7'h06;
    localparam logic [6:0] C_RAMP_UP = 7'h08;
    localparam logic [6:0] C_RAMP_DN = 7'h09;
    localparam logic [6:0] C_SPD_LIM = 7'h0A;
    localparam logic [6:0] C_PAD_A = 7'h12;
    localparam logic [6:0] C_PAD_B = 7'h13;
    localparam logic [6:0] C_CTRL = 7'h14;
    localparam logic [6:0] C_TRQ_SIGN = 7'h15;
    localparam logic [6:0] C_LINE_REL = 7'h17;
    localparam logic [6:0] C_ENC1_OK = 7'h1E;
    localparam logic [6:0] C_ENC2_OK = 7'h1F;
    localparam logic [6:0] C_DRV_OK = 7'h2A;
    localparam logic [6:0] C_AIN1_MATCH = 7'h31;
    localparam logic [6:0] C_ENABLE = 7'h32;
    localparam logic [6:0] C_START = 7'h33;
    localparam logic [6:0] C_FSTOP = 7'h34;
    localparam logic [6:0] C_ACCEL = 7'h3C;
    localparam logic [6:0] C_DECEL = 7'h3D;
    localparam logic [6:0] C_BRAKE_OPEN = 7'h3E;
    localparam logic [6:0] C_MOT_ALERT = 7'h41;
    localparam logic [6:0] C_DRV_ALERT = 7'h42;
    localparam logic [6:0] C_DRV_OVL_FREE = 7'h43;
    localparam logic [6:0] C_ARM_CUR_THR = 7'h46;
    localparam logic [6:0] C_READY_RUN = 7'h4C;
    localparam logic [6:0] C_REMOTE = 7'h4D;
    localparam logic [6:0] C_FIRING = 7'h50;
    localparam logic [6:0] C_CONT_COND = 7'h51;
    localparam logic [6:0] C_ON = 7'h64;

    // alarm codes, indexed like the alarm input vector
    localparam logic [6:0] ALM_CODE [N_ALM] = '{
        7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h18, 7'h19,
        7'h1A, 7'h23, 7'h3F, 7'h44, 7'h45, 7'h47, 7'h48, 7'h52};

    // thermal load percentage at which an alert is raised
    localparam logic [7:0] THERMAL_ALERT_PCT = 8'h50;

    // -------------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_SEL0 = 8'h00;
    localparam logic [7:0] OFS_INV = 8'h20;
    localparam logic [7:0] OFS_PAD_A = 8'h24;
    localparam logic [7:0] OFS_PAD_B = 8'h28;
    localparam logic [7:0] OFS_MON = 8'h2C;
    localparam logic [7:0] OFS_CTRL_MON = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;

    localparam logic [6:0] RST_SEL = 7'h00;
    localparam logic [7:0] RST_INV = 8'h00;
    localparam logic [15:0] RST_PAD = 16'h0000;
endpackage : ofs_pkg

// [logic/ofs_out_sel.sv]
// one digital output: source select, inversion, output flop
`timescale 1ns/100ps
module ofs_out_sel
    import ofs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // selection
    input wire logic [SEL_W-1:0] code_i,
    input wire logic inv_i,
    // sources
    input wire logic [SRC_N-1:0] src_i,
    input wire logic pad_a_bit_i,
    input wire logic pad_b_bit_i,
    input wire logic ctrl_bit_i,
    // line
    output logic out_o
);
    logic pick;
    logic out_d;

    // per-output word bits override the shared vector
    assign pick = (code_i == C_PAD_A) ? pad_a_bit_i :
                  (code_i == C_PAD_B) ? pad_b_bit_i :
                  (code_i == C_CTRL)  ? ctrl_bit_i :
                  src_i[code_i];
    assign out_d = pick ^ inv_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_o <= 1'b0;
        end else begin
            out_o <= out_d;
        end
    end
endmodule : ofs_out_sel

// [logic/ofs_top.sv]
// digital output function selector with wishbone register access
// Function
// - eight outputs, each its own selection code
// - code zero holds output low
// - code one hundred holds output high
// - code eighteen: output n shows pad A bit n-1
// - code nineteen: output n shows pad B bit n-1
// - code twenty: output n shows command word bit n-1
// - alarm codes map to their alarm conditions
// - alarm sources drive the output active low
// - alarm outputs track alarms even when ignored
// - ready-to-run: supply, no alarm, mains synchronized
// - codes 1-3: zero speed, thresholds, speed reached
// - codes 8,9,60,61: ramp direction and phase flags
// - codes 65,66: thermal alerts at eighty percent
// - codes 5,42,50-52: ready, healthy, enable, start, fast-stop
// - codes 30,31: encoder one and two health
// - codes 80,81: gating active, continuous conduction
// - codes 62,63: brake open command, brake fault
// - codes 21,23: torque sign, line switch release
// - codes 4,70: current limit, armature current threshold
// - per-output inversion applied before the line
// - readable monitor of each final output state
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module ofs_top
    import ofs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // speed and ramp status
    input wire logic speed_zero_i,
    input wire logic speed_in_thr_i,
    input wire logic speed_reached_i,
    input wire logic speed_limited_i,
    input wire logic ramp_up_i,
    input wire logic ramp_down_i,
    input wire logic accel_i,
    input wire logic decel_i,
    // drive state
    input wire logic cur_limit_i,
    input wire logic drive_ready_i,
    input wire logic drive_ok_i,
    input wire logic enable_i,
    input wire logic start_i,
    input wire logic fast_stop_i,
    input wire logic remote_i,
    input wire logic torque_neg_i,
    input wire logic line_release_i,
    input wire logic enc1_ok_i,
    input wire logic enc2_ok_i,
    input wire logic ain1_match_i,
    input wire logic brake_open_i,
    input wire logic arm_cur_thr_i,
    input wire logic firing_i,
    input wire logic cont_cond_i,
    // protection
    input wire logic motor_ovl_free_i,
    input wire logic drive_ovl_free_i,
    input wire logic [7:0] motor_load_pct_i,
    input wire logic [7:0] drive_load_pct_i,
    input wire logic [N_ALM-1:0] alarm_i,
    // supply
    input wire logic supply_ok_i,
    input wire logic mains_sync_i,
    // command word monitor
    input wire logic [15:0] ctrl_word_i,
    // output lines
    output logic [N_OUT-1:0] dout_o
);
    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    logic [SEL_W-1:0] sel_q [N_OUT];
    logic [N_OUT-1:0] inv_q;
    logic [15:0] pad_a_q;
    logic [15:0] pad_b_q;
    logic ack_q;
    logic [31:0] rdat_q;

    // -------------------------------------------------------------------
    // derived status
    // -------------------------------------------------------------------
    logic any_alarm;
    logic ready_run_flag;
    logic motor_thermal_alert;
    logic drive_thermal_alert;
    logic [SRC_N-1:0] src;

    assign any_alarm = |alarm_i;
    assign ready_run_flag = supply_ok_i & ~any_alarm & mains_sync_i;
    // alerts compare load against the threshold, not the trip level
    assign motor_thermal_alert = (motor_load_pct_i >= THERMAL_ALERT_PCT);
    assign drive_thermal_alert = (drive_load_pct_i >= THERMAL_ALERT_PCT);

    // -------------------------------------------------------------------
    // shared source vector, unused codes stay low
    // -------------------------------------------------------------------
    always_comb begin
        src = '0;
        src[C_OFF] = 1'b0;
        src[C_ON] = 1'b1;
        src[C_SPD_ZERO] = speed_zero_i;
        src[C_SPD_THR] = speed_in_thr_i;
        src[C_SPD_SET] = speed_reached_i;
        src[C_CUR_LIM] = cur_limit_i;
        src[C_DRV_RDY] = drive_ready_i;
        src[C_MOT_OVL_FREE] = motor_ovl_free_i;
        src[C_RAMP_UP] = ramp_up_i;
        src[C_RAMP_DN] = ramp_down_i;
        src[C_SPD_LIM] = speed_limited_i;
        src[C_TRQ_SIGN] = torque_neg_i;
        src[C_LINE_REL] = line_release_i;
        src[C_ENC1_OK] = enc1_ok_i;
        src[C_ENC2_OK] = enc2_ok_i;
        src[C_DRV_OK] = drive_ok_i;
        src[C_AIN1_MATCH] = ain1_match_i;
        src[C_ENABLE] = enable_i;
        src[C_START] = start_i;
        src[C_FSTOP] = fast_stop_i;
        src[C_ACCEL] = accel_i;
        src[C_DECEL] = decel_i;
        src[C_BRAKE_OPEN] = brake_open_i;
        src[C_MOT_ALERT] = motor_thermal_alert;
        src[C_DRV_ALERT] = drive_thermal_alert;
        src[C_DRV_OVL_FREE] = drive_ovl_free_i;
        src[C_ARM_CUR_THR] = arm_cur_thr_i;
        src[C_READY_RUN] = ready_run_flag;
        src[C_REMOTE] = remote_i;
        src[C_FIRING] = firing_i;
        src[C_CONT_COND] = cont_cond_i;
        // raw alarm state, no ignore setting can mask it
        for (int a = 0; a < N_ALM; a++) begin
            src[ALM_CODE[a]] = ~alarm_i[a];
        end
    end

    // -------------------------------------------------------------------
    // output channels
    // -------------------------------------------------------------------
    for (genvar k = 0; k < N_OUT; k++) begin : g_out
        ofs_out_sel u_sel (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .code_i(sel_q[k]),
            .inv_i(inv_q[k]),
            .src_i(src),
            .pad_a_bit_i(pad_a_q[k]),
            .pad_b_bit_i(pad_b_q[k]),
            .ctrl_bit_i(ctrl_word_i[k]),
            .out_o(dout_o[k])
        );
    end

    // -------------------------------------------------------------------
    // wishbone decode
    // -------------------------------------------------------------------
    logic req;
    logic wr_en;
    logic sel_hit;
    logic [2:0] sel_idx;
    logic [SEL_W-1:0] sel_rd;
    logic [31:0] rd_data;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_en = req & wb_we_i;
    assign sel_hit = (wb_adr_i[7:5] == OFS_SEL0[7:5]);
    assign sel_idx = wb_adr_i[4:2];
    assign sel_rd = sel_q[sel_idx];
    // unmapped addresses still acknowledge and read as zero
    assign rd_data = sel_hit ? {25'h000_0000, sel_rd} :
                     (wb_adr_i == OFS_INV) ? {24'h00_0000, inv_q} :
                     (wb_adr_i == OFS_PAD_A) ? {16'h0000, pad_a_q} :
                     (wb_adr_i == OFS_PAD_B) ? {16'h0000, pad_b_q} :
                     (wb_adr_i == OFS_MON) ? {24'h00_0000, dout_o} :
                     (wb_adr_i == OFS_CTRL_MON) ? {16'h0000, ctrl_word_i} :
                     (wb_adr_i == OFS_STATUS) ? {28'h000_0000, drive_thermal_alert,
                                                 motor_thermal_alert, any_alarm, ready_run_flag} :
                     32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req) begin
                rdat_q <= rd_data;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // -------------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < N_OUT; i++) begin
                sel_q[i] <= RST_SEL;
            end
            inv_q <= RST_INV;
            pad_a_q <= RST_PAD;
            pad_b_q <= RST_PAD;
        end else if (wr_en) begin
            if (sel_hit && wb_sel_i[0]) begin
                sel_q[sel_idx] <= wb_dat_i[SEL_W-1:0];
            end
            if (wb_adr_i == OFS_INV && wb_sel_i[0]) begin
                inv_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == OFS_PAD_A) begin
                if (wb_sel_i[0]) pad_a_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) pad_a_q[15:8] <= wb_dat_i[15:8];
            end
            if (wb_adr_i == OFS_PAD_B) begin
                if (wb_sel_i[0]) pad_b_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) pad_b_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence wb_ans_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    wb_ack_a: assert property (wb_req_s |=> wb_ans_s)
        else $error("bus ack not a single pulse after request");

    for (genvar k = 0; k < N_OUT; k++) begin : g_chk
        off_low_a: assert property ((sel_q[k] == C_OFF && !inv_q[k]) |=> !dout_o[k])
            else $error("code zero output not low");
        on_high_a: assert property ((sel_q[k] == C_ON && !inv_q[k]) |=> dout_o[k])
            else $error("code hundred output not high");
        pad_a_a: assert property ((sel_q[k] == C_PAD_A) |=> dout_o[k] == ($past(pad_a_q[k]) ^ $past(inv_q[k])))
            else $error("pad A bit not on its output");
        pad_b_a: assert property ((sel_q[k] == C_PAD_B) |=> dout_o[k] == ($past(pad_b_q[k]) ^ $past(inv_q[k])))
            else $error("pad B bit not on its output");
        ctrl_bit_a: assert property ((sel_q[k] == C_CTRL) |=> dout_o[k] == ($past(ctrl_word_i[k]) ^ $past(inv_q[k])))
            else $error("command word bit not on its output");
        alarm_low_a: assert property ((sel_q[k] == ALM_CODE[3] && alarm_i[3] && !inv_q[k]) |=> !dout_o[k])
            else $error("active alarm did not drive output low");
        ready_run_a: assert property ((sel_q[k] == C_READY_RUN && !inv_q[k]) |=> dout_o[k] == $past(ready_run_flag))
            else $error("ready-to-run output mismatch");
        undef_low_a: assert property ((sel_q[k] == 7'h07 && !inv_q[k]) ##1 (sel_q[k] == 7'h07 && !inv_q[k]) |=> !dout_o[k])
            else $error("undefined code output not low");
        thermal_a: assert property ((sel_q[k] == C_MOT_ALERT && !inv_q[k] &&
            motor_load_pct_i >= THERMAL_ALERT_PCT) |=> dout_o[k])
            else $error("motor thermal alert missing at threshold");
        inv_on_a: assert property ((sel_q[k] == C_ON && inv_q[k]) |=> !dout_o[k])
            else $error("inverted code hundred output not low");
        ready_low_a: assert property ((sel_q[k] == C_READY_RUN && !inv_q[k] && !supply_ok_i) |=> !dout_o[k])
            else $error("ready-to-run high without supply");

        // one cycle after selection the line shows the source through inversion
        sequence shows_s(src_b);
            dout_o[k] == ($past(src_b) ^ $past(inv_q[k]));
        endsequence

        spd_zero_a: assert property ((sel_q[k] == C_SPD_ZERO) |=> shows_s(speed_zero_i))
            else $error("zero speed flag mismatch");
        spd_thr_a: assert property ((sel_q[k] == C_SPD_THR) |=> shows_s(speed_in_thr_i))
            else $error("speed threshold flag mismatch");
        spd_set_a: assert property ((sel_q[k] == C_SPD_SET) |=> shows_s(speed_reached_i))
            else $error("speed reached flag mismatch");
        ramp_up_a: assert property ((sel_q[k] == C_RAMP_UP) |=> shows_s(ramp_up_i))
            else $error("ramp up flag mismatch");
        ramp_dn_a: assert property ((sel_q[k] == C_RAMP_DN) |=> shows_s(ramp_down_i))
            else $error("ramp down flag mismatch");
        accel_a: assert property ((sel_q[k] == C_ACCEL) |=> shows_s(accel_i))
            else $error("acceleration flag mismatch");
        decel_a: assert property ((sel_q[k] == C_DECEL) |=> shows_s(decel_i))
            else $error("deceleration flag mismatch");
        drv_alert_a: assert property ((sel_q[k] == C_DRV_ALERT) |=> shows_s(drive_load_pct_i >= THERMAL_ALERT_PCT))
            else $error("drive thermal alert mismatch");
        drv_rdy_a: assert property ((sel_q[k] == C_DRV_RDY) |=> shows_s(drive_ready_i))
            else $error("drive ready flag mismatch");
        drv_ok_a: assert property ((sel_q[k] == C_DRV_OK) |=> shows_s(drive_ok_i))
            else $error("healthy running flag mismatch");
        enable_a: assert property ((sel_q[k] == C_ENABLE) |=> shows_s(enable_i))
            else $error("enable flag mismatch");
        start_a: assert property ((sel_q[k] == C_START) |=> shows_s(start_i))
            else $error("start flag mismatch");
        fstop_a: assert property ((sel_q[k] == C_FSTOP) |=> shows_s(fast_stop_i))
            else $error("fast stop flag mismatch");
        enc1_ok_a: assert property ((sel_q[k] == C_ENC1_OK) |=> shows_s(enc1_ok_i))
            else $error("encoder one health mismatch");
        enc2_ok_a: assert property ((sel_q[k] == C_ENC2_OK) |=> shows_s(enc2_ok_i))
            else $error("encoder two health mismatch");
        firing_a: assert property ((sel_q[k] == C_FIRING) |=> shows_s(firing_i))
            else $error("gating active flag mismatch");
        cont_cond_a: assert property ((sel_q[k] == C_CONT_COND) |=> shows_s(cont_cond_i))
            else $error("continuous conduction flag mismatch");
        brake_open_a: assert property ((sel_q[k] == C_BRAKE_OPEN) |=> shows_s(brake_open_i))
            else $error("brake open command mismatch");
        trq_sign_a: assert property ((sel_q[k] == C_TRQ_SIGN) |=> shows_s(torque_neg_i))
            else $error("torque sign mismatch");
        line_rel_a: assert property ((sel_q[k] == C_LINE_REL) |=> shows_s(line_release_i))
            else $error("line switch release mismatch");
        cur_lim_a: assert property ((sel_q[k] == C_CUR_LIM) |=> shows_s(cur_limit_i))
            else $error("current limit flag mismatch");
        arm_cur_a: assert property ((sel_q[k] == C_ARM_CUR_THR) |=> shows_s(arm_cur_thr_i))
            else $error("armature current threshold mismatch");

        for (genvar a = 0; a < N_ALM; a++) begin : g_alm
            alarm_map_a: assert property ((sel_q[k] == ALM_CODE[a]) |=> shows_s(!alarm_i[a]))
                else $error("alarm state not on its output");
        end
    end

    mon_read_a: assert property ((wb_req_s and (wb_adr_i == OFS_MON && !wb_we_i)) |=> wb_dat_o[7:0] == $past(dout_o))
        else $error("monitor read does not match outputs");

    sequence sel_wr_s;
        wb_req_s and (wb_we_i && sel_hit && wb_sel_i[0]);
    endsequence

    sel_write_a: assert property (sel_wr_s |=> sel_q[$past(sel_idx)] == $past(wb_dat_i[SEL_W-1:0]))
        else $error("selection write lost");
    inv_write_a: assert property ((wb_req_s and (wb_we_i && wb_adr_i == OFS_INV && wb_sel_i[0])) |=>
        inv_q == $past(wb_dat_i[7:0]))
        else $error("inversion write lost");
endmodule : ofs_top

// [dv/ofs_ext_reader.sv]
// model of the machine control equipment that reads the output lines
`timescale 1ns/100ps
module ofs_ext_reader (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // lines and pacing
    input wire logic [7:0] line_i,
    input wire logic slow_i,
    // what the equipment has taken in
    output logic [7:0] seen_o
);
    logic [7:0] stage_q;
    // slow pacing adds a second stage, like a filtered plc input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= 8'h00;
            seen_o <= 8'h00;
        end else begin
            stage_q <= line_i;
            seen_o <= slow_i ? stage_q : line_i;
        end
    end
endmodule : ofs_ext_reader

// [dv/ofs_top_tb_top.sv]
// self-checking testbench of the digital output function selector
`timescale 1ns/100ps
module ofs_top_tb_top
    import ofs_pkg::*;
;
    localparam logic [6:0] FCODE [26] = '{C_SPD_ZERO, C_SPD_THR, C_SPD_SET, C_SPD_LIM, C_RAMP_UP, C_RAMP_DN,
        C_ACCEL, C_DECEL, C_CUR_LIM, C_DRV_RDY, C_DRV_OK, C_ENABLE, C_START, C_FSTOP, C_REMOTE, C_TRQ_SIGN,
        C_LINE_REL, C_ENC1_OK, C_ENC2_OK, C_AIN1_MATCH, C_BRAKE_OPEN, C_ARM_CUR_THR, C_FIRING, C_CONT_COND,
        C_MOT_OVL_FREE, C_DRV_OVL_FREE};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] bsel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat_o;
    logic ack;
    logic [27:0] fl = '0;
    logic [7:0] mld = 8'h00;
    logic [7:0] dld = 8'h00;
    logic [N_ALM-1:0] alm = '0;
    logic [15:0] cw = 16'h0000;
    logic [7:0] dout;
    logic [7:0] seen;
    logic slow = 1'b0;
    logic [6:0] sel_s [N_OUT];
    logic [7:0] inv_s;
    logic [15:0] pa_s;
    logic [15:0] pb_s;
    logic [31:0] rdat;
    logic [31:0] wd;
    logic [3:0] rs;
    int failures = 0;
    int n_checks = 0;

    always #4 clk_i = ~clk_i;

    ofs_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(bsel), .wb_dat_i(dat), .wb_dat_o(rdat_o), .wb_ack_o(ack),
        .speed_zero_i(fl[0]), .speed_in_thr_i(fl[1]), .speed_reached_i(fl[2]), .speed_limited_i(fl[3]),
        .ramp_up_i(fl[4]), .ramp_down_i(fl[5]), .accel_i(fl[6]), .decel_i(fl[7]), .cur_limit_i(fl[8]),
        .drive_ready_i(fl[9]), .drive_ok_i(fl[10]), .enable_i(fl[11]), .start_i(fl[12]), .fast_stop_i(fl[13]),
        .remote_i(fl[14]), .torque_neg_i(fl[15]), .line_release_i(fl[16]), .enc1_ok_i(fl[17]),
        .enc2_ok_i(fl[18]), .ain1_match_i(fl[19]), .brake_open_i(fl[20]), .arm_cur_thr_i(fl[21]),
        .firing_i(fl[22]), .cont_cond_i(fl[23]), .motor_ovl_free_i(fl[24]), .drive_ovl_free_i(fl[25]),
        .motor_load_pct_i(mld), .drive_load_pct_i(dld), .alarm_i(alm), .supply_ok_i(fl[26]),
        .mains_sync_i(fl[27]), .ctrl_word_i(cw), .dout_o(dout));

    ofs_ext_reader reader (.clk_i(clk_i), .rst_i(rst_i), .line_i(dout), .slow_i(slow), .seen_o(seen));

    // -------------------------------------------------------------------
    // expectation
    // -------------------------------------------------------------------
    function automatic logic src_bit(input logic [6:0] c, input int k);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 26; i++) if (c == FCODE[i]) r = fl[i];
        // alarm sources are active low
        for (int i = 0; i < N_ALM; i++) if (c == ALM_CODE[i]) r = ~alm[i];
        if (c == C_READY_RUN) r = fl[26] & ~(|alm) & fl[27];
        if (c == C_MOT_ALERT) r = (mld >= THERMAL_ALERT_PCT);
        if (c == C_DRV_ALERT) r = (dld >= THERMAL_ALERT_PCT);
        if (c == C_PAD_A) r = pa_s[k];
        if (c == C_PAD_B) r = pb_s[k];
        if (c == C_CTRL) r = cw[k];
        if (c == C_ON) r = 1'b1;
        return r;
    endfunction : src_bit

    function automatic logic [7:0] exp_out();
        logic [7:0] e;
        for (int k = 0; k < N_OUT; k++) e[k] = src_bit(sel_s[k], k) ^ inv_s[k];
        return e;
    endfunction : exp_out

    // -------------------------------------------------------------------
    // bus, compare and closing tasks
    // -------------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        bsel <= s;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 100);
        if (ack !== 1'b1) begin
            failures++;
            conclude();
        end
        q = rdat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_line(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_line

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    // sweep needs about 6.5k cycles; limit leaves ample margin
    initial begin
        #400000;
        failures++;
        conclude();
    end

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        void'($urandom(43));
        foreach (sel_s[k]) sel_s[k] = 7'h00;
        inv_s = 8'h00;
        pa_s = 16'h0000;
        pb_s = 16'h0000;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 48; a += 4) begin
            wb(1'b0, 8'(a), 32'h0000_0000, 4'hF, rdat);
            chk_word("reset register", 32'h0000_0000, rdat);
        end
        chk_line("reset lines", 8'h00, dout);
        wb(1'b1, 8'hFC, 32'hFFFF_FFFF, 4'hF, rdat);
        wb(1'b0, 8'hFC, 32'h0000_0000, 4'hF, rdat);
        chk_word("unmapped", 32'h0000_0000, rdat);
        // every code on every output, then all outputs on the bit-word codes
        for (int it = 0; it < 131; it++) begin
            for (int k = 0; k < N_OUT; k++) begin
                sel_s[k] = (it < 128) ? 7'((it + k * 17) % 128) : (it == 128) ? C_PAD_A : (it == 129) ? C_PAD_B : C_CTRL;
                wb(1'b1, 8'(4 * k), {25'h0, sel_s[k]}, 4'h1, rdat);
            end
            wb(1'b0, 8'(4 * (it % 8)), 32'h0000_0000, 4'hF, rdat);
            chk_word("sel code", {25'h0, sel_s[it % 8]}, rdat);
            inv_s = 8'($urandom);
            wb(1'b1, OFS_INV, {24'h0, inv_s}, 4'h1, rdat);
            rs = 4'($urandom);
            wd = $urandom;
            wb(1'b1, OFS_PAD_A, wd, rs, rdat);
            if (rs[0]) pa_s[7:0] = wd[7:0];
            if (rs[1]) pa_s[15:8] = wd[15:8];
            rs = 4'($urandom);
            wd = $urandom;
            wb(1'b1, OFS_PAD_B, wd, rs, rdat);
            if (rs[0]) pb_s[7:0] = wd[7:0];
            if (rs[1]) pb_s[15:8] = wd[15:8];
            fl <= 28'($urandom);
            alm <= (it % 3 == 0) ? '0 : (it % 3 == 1) ? (17'h1 << (it % 17)) : 17'($urandom);
            mld <= 8'($urandom_range(78, 82));
            dld <= 8'($urandom_range(0, 160));
            cw <= 16'($urandom);
            slow <= 1'(it >> 1);
            repeat (4) @(posedge clk_i);
            chk_line("lines", exp_out(), dout);
            chk_line("reader", exp_out(), seen);
            wb(1'b0, OFS_MON, 32'h0000_0000, 4'hF, rdat);
            chk_word("monitor", {24'h0, exp_out()}, rdat);
            wd = {28'h0, dld >= THERMAL_ALERT_PCT, mld >= THERMAL_ALERT_PCT, |alm, fl[26] & ~(|alm) & fl[27]};
            wb(1'b0, OFS_STATUS, 32'h0000_0000, 4'hF, rdat);
            chk_word("status", wd, rdat);
            wb(1'b0, OFS_CTRL_MON, 32'h0000_0000, 4'hF, rdat);
            chk_word("command word", {16'h0, cw}, rdat);
        end
        conclude();
    end
endmodule : ofs_top_tb_top
